// ### verification/filter_address_branch_ctrl_tb.sv
/*
  Self-checking bench for the filter sequencer: loads both address RAMs, the
  branch table and a program over APB, runs it and compares every executed
  control word and both address unit outputs with a behavioural model.
  Assumes fab_pkg and fab_ctrl are compiled first; one 50 MHz clock.
*/
`timescale 1ns/1ps
module filter_address_branch_ctrl_tb;
  import fab_pkg::*;
  localparam int LASTPC = 24;
  logic            clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, ctrl_word, rd, seed;
  logic [1:0]      dp_flags, global_in;
  logic [AW-1:0]   acu_a_addr, acu_b_addr;
  logic [PC_W-1:0] pc;
  int              err_count, comparisons;
  int              aop[25], aix[25], bop[25], ra[16], rb[16], sa[5], sb[5];
  int              ben[5], btg[5], bnx[5], bpool[13];
  logic [31:0]     word[25];
  logic [31:0]     cap_w[$], exp_w[$];
  logic [6:0]      cap_a[$], cap_b[$];
  int              exp_a[$], exp_b[$];

  fab_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .dp_flags(dp_flags),
    .global_in(global_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acu_a_addr(acu_a_addr), .acu_b_addr(acu_b_addr), .ctrl_word(ctrl_word), .pc(pc));

  // Clock generator, 20 ns period
  always #10 clk = ~clk;

  // Record every executed word with both unit outputs
  always @(posedge clk) begin
    if (ctrl_word[12] === 1'b1) begin
      cap_w.push_back(ctrl_word);
      cap_a.push_back(acu_a_addr);
      cap_b.push_back(acu_b_addr);
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction

  // Address unit model: st holds address, step, lower, upper, wrap flag
  function automatic int acu_fn(input int f, input int ix, ref int st[5], ref int ram[16]);
    int o;
    int s;
    o = st[0];
    case (f)
      1: begin
        if (st[4] != 0 && st[0] == st[3]) o = st[2];
        else if (st[4] == 0 && st[0] == 127) o = 0;
        else o = st[0] + 1;
        st[0] = o & 127;
      end
      2: begin
        if (st[4] != 0 && st[0] == st[2]) o = st[3];
        else if (st[4] == 0 && st[0] == 0) o = 127;
        else o = st[0] - 1;
        st[0] = o & 127;
      end
      3: begin o = ram[ix]; st[0] = o; end
      4: ram[ix] = o;
      5: st[1] = ram[ix];
      6: st[2] = ram[ix];
      7: st[3] = ram[ix];
      8: begin o = st[2]; ram[ix] = o; end
      9: st[4] = 1;
      10: st[4] = 0;
      11: begin o = (st[4] != 0) ? st[2] : 0; st[0] = o; end
      12: begin
        s = st[0] + st[1];
        if (st[4] != 0 && s > st[3]) o = s - st[3] - 1 + st[2];
        else if (st[4] == 0 && s > 127) o = s - 127 - 1;
        else o = s;
        st[0] = o & 127;
      end
      13: begin
        s = st[0] - st[1];
        if (st[4] != 0 && s < st[2]) o = st[3] - ((st[1] - (st[0] - st[2])) - 1);
        else if (st[4] == 0 && s < 0) o = 127 - ((st[1] - st[0]) - 1);
        else o = s;
        st[0] = o & 127;
      end
      14: begin o = st[3]; ram[ix] = o; end
      15: begin o = st[1]; ram[ix] = o; end
      default: o = st[0];
    endcase
    return o & 127;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; read data and error flag land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "bus answer missing");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake or a runaway program
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end

  initial begin
    int p, bs, fl, ea, eb, r;
    clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; dp_flags = 2'b01; global_in = 2'b00;
    err_count = 0; comparisons = 0; seed = 32'h29c8_db60;
    aop = '{3, 5, 6, 7, 9, 1, 0, 0, 0, 12, 13, 11, 14, 15, 10, 3, 12, 13, 11, 2, 1, 4, 8, 3, 0};
    aix = '{3, 0, 1, 2, 0, 0, 0, 0, 0, 0, 0, 0, 4, 5, 0, 6, 0, 0, 0, 0, 0, 7, 8, 4, 0};
    bpool = '{0, 1, 2, 3, 4, 8, 9, 10, 11, 12, 13, 14, 15};
    ben = '{1, 1, 1, 4, 0};
    btg = '{5, 5, 5, 9, 0};
    bnx = '{1, 2, 3, 4, 4};
    ra = '{3, 10, 20, 16, 0, 0, 126, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    sa = '{0, 0, 0, 0, 0};
    sb = '{0, 0, 0, 0, 0};
    // Sane step and bounds for unit B, the rest random
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      r = int'(seed[15:0]);
      rb[i] = (i == 0) ? 1 + r % 15 : (i == 1) ? r % 32 : (i == 2) ? 64 + r % 32 : r % 128;
    end
    for (int i = 0; i < 25; i++) begin
      seed = lfsr(seed);
      bop[i] = (i == 0) ? 0 : (i < 4) ? i + 4 : bpool[int'(seed[7:0]) % 13];
      word[i] = {(i == 5 || i == 6 || i == LASTPC) ? 1'b1 : 1'b0, 4'(aix[i]), 4'(aop[i]),
                 4'(bop[i]), 6'(i), 1'b1, 12'h000};
    end
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h0, "status after reset");
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rd, 32'h0, "addresses after reset");
    apb(1'b0, 12'h0FF0, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error flag");
    chk(rd, 32'h0, "unmapped read data");
    // Load address RAMs, branch table and control store 0
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'(ACU_A_BASE + 4 * i), 32'(ra[i]));
      apb(1'b1, 12'(ACU_B_BASE + 4 * i), 32'(rb[i]));
    end
    for (int i = 0; i < 5; i++)
      apb(1'b1, 12'(BRANCH_BASE + 4 * i), 32'(btg[i] | (bnx[i] << 6) | (ben[i] << 9)));
    for (int i = 0; i < 25; i++)
      apb(1'b1, 12'(STORE0_BASE + 4 * i), word[i]);
    apb(1'b1, LAST_OFS, 32'(LASTPC));
    apb(1'b0, LAST_OFS, 32'h0);
    chk(rd & 32'h0000_003F, 32'(LASTPC), "last index readback");
    // Behavioural run of the program
    p = 0;
    bs = 0;
    for (int k = 0; k < 200; k++) begin
      fl = 1 | ((sa[0] == sa[3] || sa[0] == 127 || sa[0] == 0) ? 4 : 0)
             | ((sb[0] == sb[3] || sb[0] == 127 || sb[0] == 0) ? 8 : 0);
      ea = acu_fn(aop[p], aix[p], sa, ra);
      eb = acu_fn(bop[p], aix[p], sb, rb);
      exp_w.push_back(word[p]);
      exp_a.push_back(ea);
      exp_b.push_back(eb);
      if (word[p][31] && (ben[bs] & fl) != 0) begin
        p = btg[bs];
        bs = bnx[bs];
      end else if (p == LASTPC) break;
      else p++;
    end
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, STATUS_OFS, 32'h0);
      if (rd[7] === 1'b1) break;
    end
    chk(rd & 32'h0000_07C0, 32'((bs << 8) | 128), "final status");
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rd, 32'((sb[0] << 8) | sa[0]), "final addresses");
    if (cap_w.size() + 1 < exp_w.size() || cap_w.size() > exp_w.size())
      chk(32'(cap_w.size()), 32'(exp_w.size()), "executed word count");
    for (int i = 0; i < cap_w.size() && i < exp_w.size(); i++) begin
      chk(cap_w[i], exp_w[i], "executed word");
      chk(32'(cap_a[i]), 32'(exp_a[i]), "unit A output");
      chk(32'(cap_b[i]), 32'(exp_b[i]), "unit B output");
    end
    print_verdict();
  end
endmodule

// ### verilog/fab_acu.sv
/*
  One address calculation unit: current address, step, lower and upper
  bounds, wrap flag and its own 16-word address RAM.
  Assumes step is high only while the sequencer executes an instruction.
*/
`timescale 1ns/1ps
module fab_acu (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 step,
  input  wire logic [3:0]           func,
  input  wire logic [3:0]           ram_addr,
  input  wire logic                 sw_we,
  input  wire logic [3:0]           sw_addr,
  input  wire logic [fab_pkg::AW-1:0] sw_data,
  output logic      [fab_pkg::AW-1:0] addr_out,
  output logic      [fab_pkg::AW-1:0] cur_addr,
  output logic                      eq_flag
);
  import fab_pkg::*;

  logic [AW-1:0] addr_ff, step_ff, low_ff, up_ff;
  logic          wrap_ff;
  logic [AW-1:0] ram [ACU_RAM_DEPTH];
  logic [AW-1:0] nxt_addr, nxt_out, ram_rd;
  logic          nxt_wrap, ram_we, ld_step, ld_low, ld_up;
  logic [AW:0]   sum, diff, add_wrap, sub_wrap, sub_neg;

  // Wide arithmetic keeps the carry and borrow visible
  assign ram_rd   = ram[ram_addr];
  assign sum      = {1'b0, addr_ff} + {1'b0, step_ff};
  assign diff     = {1'b0, addr_ff} - {1'b0, step_ff};
  assign add_wrap = sum - {1'b0, up_ff} - 8'h01 + {1'b0, low_ff};
  assign sub_wrap = {1'b0, up_ff} - ({1'b0, step_ff} - ({1'b0, addr_ff} - {1'b0, low_ff}) - 8'h01);
  assign sub_neg  = {1'b0, ADDR_TOP} - ({1'b0, step_ff} - {1'b0, addr_ff} - 8'h01);
  assign addr_out = nxt_out;
  assign cur_addr = addr_ff;
  // Equal flag on upper bound, top address 127 or zero
  assign eq_flag  = (addr_ff == up_ff) || (addr_ff == ADDR_TOP) || (addr_ff == 7'h00);

  // Function decode
  always_comb begin
    nxt_out  = addr_ff;
    nxt_addr = addr_ff;
    nxt_wrap = wrap_ff;
    ram_we   = 1'b0;
    ld_step  = 1'b0;
    ld_low   = 1'b0;
    ld_up    = 1'b0;
    case (func)
      INC_OP: begin
        if (wrap_ff && addr_ff == up_ff) nxt_out = low_ff;
        else if (!wrap_ff && addr_ff == ADDR_TOP) nxt_out = 7'h00;
        else nxt_out = addr_ff + 7'h01;
        nxt_addr = nxt_out;
      end
      DEC_OP: begin
        if (wrap_ff && addr_ff == low_ff) nxt_out = up_ff;
        else if (!wrap_ff && addr_ff == 7'h00) nxt_out = ADDR_TOP;
        else nxt_out = addr_ff - 7'h01;
        nxt_addr = nxt_out;
      end
      READ_OP: begin
        nxt_out  = ram_rd;
        nxt_addr = ram_rd;
      end
      WRITE_OP:       ram_we = 1'b1;
      LOAD_STEP_OP:   ld_step = 1'b1;
      LOAD_LOW_OP:    ld_low = 1'b1;
      LOAD_UP_OP:     ld_up = 1'b1;
      STORE_LOW_OP: begin
        nxt_out = low_ff;
        ram_we  = 1'b1;
      end
      WRAP_ON_OP:     nxt_wrap = 1'b1;
      WRAP_OFF_OP:    nxt_wrap = 1'b0;
      CLEAR_OP: begin
        nxt_out  = wrap_ff ? low_ff : 7'h00;
        nxt_addr = nxt_out;
      end
      STEP_UP_OP: begin
        if (wrap_ff && sum > {1'b0, up_ff}) nxt_out = add_wrap[AW-1:0];
        else if (!wrap_ff && sum > {1'b0, ADDR_TOP}) nxt_out = sum[AW-1:0] - 7'h01 - ADDR_TOP;
        else nxt_out = sum[AW-1:0];
        nxt_addr = nxt_out;
      end
      STEP_DOWN_OP: begin
        if (wrap_ff && (diff[AW] || diff[AW-1:0] < low_ff)) nxt_out = sub_wrap[AW-1:0];
        else if (!wrap_ff && diff[AW]) nxt_out = sub_neg[AW-1:0];
        else nxt_out = diff[AW-1:0];
        nxt_addr = nxt_out;
      end
      STORE_UPPER_OP: begin
        nxt_out = up_ff;
        ram_we  = 1'b1;
      end
      STORE_STEP_OP: begin
        nxt_out = step_ff;
        ram_we  = 1'b1;
      end
      default: nxt_out = addr_ff;
    endcase
  end

  // Address unit registers update on the clock edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_ff <= 7'h00;
      step_ff <= 7'h00;
      low_ff  <= 7'h00;
      up_ff   <= 7'h00;
      wrap_ff <= 1'b0;
    end else if (step) begin
      addr_ff <= nxt_addr;
      wrap_ff <= nxt_wrap;
      if (ld_step) step_ff <= ram_rd;
      if (ld_low) low_ff <= ram_rd;
      if (ld_up) up_ff <= ram_rd;
    end
  end

  // Address RAM; the engine has priority over software
  always_ff @(posedge clk) begin
    if (step && ram_we) ram[ram_addr] <= nxt_out;
    else if (sw_we) ram[sw_addr] <= sw_data;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  clear_wrap_a: assert property (step && func == CLEAR_OP |=>
    addr_ff == ($past(wrap_ff) ? $past(low_ff) : 7'h00)) else $error("clear wrong");
  step_up_a: assert property (step && func == STEP_UP_OP && !wrap_ff && sum <= 8'h7F |=>
    addr_ff == $past(sum[AW-1:0])) else $error("step up wrong");
  step_down_a: assert property (step && func == STEP_DOWN_OP && !wrap_ff && diff[AW] |=>
    addr_ff == $past(sub_neg[AW-1:0])) else $error("step down wrong");
  store_hold_a: assert property (step && (func == STORE_UPPER_OP || func == STORE_STEP_OP)
    |=> $stable(addr_ff)) else $error("store moved address");
  wrap_set_a: assert property (step && func == WRAP_ON_OP |=> wrap_ff && $stable(addr_ff))
    else $error("wrap not set");
endmodule

// ### verilog/fab_ctrl.sv
/*
  Filter engine sequencer: two control stores, a branch state machine with
  its table, two address units and an APB register slave.
  Assumes a 32-bit APB master on clk; global inputs arrive from pins.
*/
// The APB interface to the registers and the placing of the registers were left to the implementer.
// What this block does
// - Code 11 loads lower bound when wrapping, else zero, into address.
// - Code 12 adds step, wrapping past upper bound or past 127.
// - Code 13 subtracts step, wrapping below lower bound or below zero.
// - Code 14 outputs upper bound, writes address RAM, holds address.
// - Code 15 outputs step, writes address RAM, holds address.
// - Sequencer uses two control stores and a branch state machine.
// - Without branches the counter runs from zero to the last instruction.
// - Each cycle enabled flags and globals are evaluated for a jump.
// - Jumps happen only on a word with the block end bit set.
// - Branch table holds next state, condition enables and jump target.
// - Equal flag rises on upper bound match, address end or zero.
// - Enabled equal flag branches on a block end word while the address sits at its upper bound, 127 or zero.
// - Two address units, each driven by a four-bit function code.
// - Control words are 32 bits with one block end bit.
// - Code 9 sets wrap mode, code 10 clears it, address held.
`timescale 1ns/1ps
module fab_ctrl (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [1:0]                   dp_flags,
  input  wire logic [1:0]                   global_in,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic      [fab_pkg::AW-1:0]       acu_a_addr,
  output logic      [fab_pkg::AW-1:0]       acu_b_addr,
  output logic      [31:0]                  ctrl_word,
  output logic      [fab_pkg::PC_W-1:0]     pc
);
  import fab_pkg::*;

  logic [31:0]      store0 [CS_DEPTH];
  logic [31:0]      store1 [CS_DEPTH];
  logic [31:0]      branch_ram [BR_DEPTH];
  fab_seq_t         seq_ff, nxt_seq;
  logic [PC_W-1:0]  pc_ff, nxt_pc, last_ff;
  logic [ST_W-1:0]  bst_ff, nxt_bst;
  logic             sel_ff, done_ff;
  logic [1:0]       glob_m_ff, glob_s_ff;
  logic             pready_ff, pslverr_ff;
  logic [31:0]      prdata_ff, ctrl_word_ff;
  logic [AW-1:0]    acu_a_ff, acu_b_ff, a_out, b_out, a_cur, b_cur;
  logic             eq_a, eq_b;

  // APB decode
  wire        access   = psel && penable;
  wire        commit   = access && pready_ff;
  wire        wr       = commit && pwrite;
  wire        hit_ctrl = paddr == CTRL_OFS;
  wire        hit_stat = paddr == STATUS_OFS;
  wire        hit_last = paddr == LAST_OFS;
  wire        hit_addr = paddr == ADDR_OFS;
  wire        hit_cs0  = paddr[11:8] == STORE0_BASE[11:8];
  wire        hit_cs1  = paddr[11:8] == STORE1_BASE[11:8];
  wire        hit_br   = paddr[11:5] == BRANCH_BASE[11:5];
  wire        hit_aa   = paddr[11:6] == ACU_A_BASE[11:6];
  wire        hit_ab   = paddr[11:6] == ACU_B_BASE[11:6];
  wire        mapped   = hit_ctrl || hit_stat || hit_last || hit_addr || hit_cs0
                         || hit_cs1 || hit_br || hit_aa || hit_ab;
  wire [PC_W-1:0] cs_idx = paddr[PC_W+1:2];
  wire [ST_W-1:0] br_idx = paddr[ST_W+1:2];
  wire [3:0]      ar_idx = paddr[5:2];
  wire        start    = wr && hit_ctrl && pwdata[CTRL_START_BIT];
  wire        stop     = wr && hit_ctrl && pwdata[CTRL_STOP_BIT];

  // Read data selection
  wire [31:0] rd_stat  = {20'h0000_0, 1'b0, bst_ff, done_ff, seq_ff == SEQ_RUN, pc_ff};
  wire [31:0] rd_data  = hit_ctrl ? {30'h0000_0000, sel_ff, 1'b0} :
                         hit_stat ? rd_stat :
                         hit_last ? {26'h0000_000, last_ff} :
                         hit_addr ? {16'h0000, 1'b0, b_cur, 1'b0, a_cur} :
                         hit_cs0  ? store0[cs_idx] :
                         hit_cs1  ? store1[cs_idx] :
                         hit_br   ? branch_ram[br_idx] : 32'h0000_0000;

  // Fetch from the selected control store
  wire        run      = seq_ff == SEQ_RUN;
  wire [31:0] cw       = sel_ff ? store1[pc_ff] : store0[pc_ff];
  wire        block_end_bit      = cw[CW_EOB_BIT];
  wire [3:0]  func_a   = cw[CW_ACUA_LSB +: 4];
  wire [3:0]  func_b   = cw[CW_ACUB_LSB +: 4];
  wire [3:0]  aram     = cw[CW_ARAM_LSB +: 4];
  // Branch table entry for the current branch state
  wire [31:0]       br_ent  = branch_ram[bst_ff];
  wire [PC_W-1:0]   br_tgt  = br_ent[BR_TGT_LSB +: PC_W];
  wire [ST_W-1:0]   br_nxt  = br_ent[BR_NXT_LSB +: ST_W];
  wire [COND_W-1:0] br_en   = br_ent[BR_EN_LSB +: COND_W];
  // Enabled flags decide the jump condition each cycle
  wire [COND_W-1:0] flags   = {glob_s_ff, eq_b, eq_a, dp_flags};
  wire              cond    = |(flags & br_en);
  wire              jump    = run && block_end_bit && cond;
  wire              at_last = pc_ff == last_ff;

  // Two address units
  fab_acu u_acu_a (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .step     (run),
    .func     (func_a),
    .ram_addr (aram),
    .sw_we    (wr && hit_aa),
    .sw_addr  (ar_idx),
    .sw_data  (pwdata[AW-1:0]),
    .addr_out (a_out),
    .cur_addr (a_cur),
    .eq_flag  (eq_a)
  );
  fab_acu u_acu_b (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .step     (run),
    .func     (func_b),
    .ram_addr (aram),
    .sw_we    (wr && hit_ab),
    .sw_addr  (ar_idx),
    .sw_data  (pwdata[AW-1:0]),
    .addr_out (b_out),
    .cur_addr (b_cur),
    .eq_flag  (eq_b)
  );

  // Sequencer next state
  always_comb begin
    nxt_seq = seq_ff;
    nxt_pc  = pc_ff;
    nxt_bst = bst_ff;
    case (seq_ff)
      SEQ_IDLE, SEQ_DONE: begin
        if (start) begin
          nxt_seq = SEQ_RUN;
          nxt_pc  = '0;
          nxt_bst = '0;
        end
      end
      SEQ_RUN: begin
        if (stop) begin
          nxt_seq = SEQ_IDLE;
        end else if (jump) begin
          nxt_pc  = br_tgt;
          nxt_bst = br_nxt;
        end else if (at_last) begin
          nxt_seq = SEQ_DONE;
        end else begin
          nxt_pc = pc_ff + 6'h01;
        end
      end
      default: nxt_seq = SEQ_IDLE;
    endcase
  end

  // Sequencer registers; reset clears the program counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_ff  <= SEQ_IDLE;
      pc_ff   <= '0;
      bst_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      seq_ff  <= nxt_seq;
      pc_ff   <= nxt_pc;
      bst_ff  <= nxt_bst;
      done_ff <= (nxt_seq == SEQ_DONE);
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_ff  <= 1'b0;
      last_ff <= '0;
    end else begin
      if (wr && hit_ctrl) sel_ff <= pwdata[CTRL_SEL_BIT];
      if (wr && hit_last) last_ff <= pwdata[PC_W-1:0];
    end
  end

  // Program and branch table memories
  always_ff @(posedge clk) begin
    if (wr && hit_cs0) store0[cs_idx] <= pwdata;
    if (wr && hit_cs1) store1[cs_idx] <= pwdata;
    if (wr && hit_br) branch_ram[br_idx] <= pwdata;
  end

  // Global inputs pass two flip-flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      glob_m_ff <= 2'b00;
      glob_s_ff <= 2'b00;
    end else begin
      glob_m_ff <= global_in;
      glob_s_ff <= glob_m_ff;
    end
  end

  // APB answer: one wait cycle, then ready with registered data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && !mapped;
      prdata_ff  <= (access && !pready_ff && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Registered datapath outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acu_a_ff     <= '0;
      acu_b_ff     <= '0;
      ctrl_word_ff <= 32'h0000_0000;
    end else begin
      acu_a_ff     <= run ? a_out : a_cur;
      acu_b_ff     <= run ? b_out : b_cur;
      ctrl_word_ff <= run ? cw : 32'h0000_0000;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign acu_a_addr = acu_a_ff;
  assign acu_b_addr = acu_b_ff;
  assign ctrl_word  = ctrl_word_ff;
  assign pc         = pc_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  jump_block_a: assert property (run && !block_end_bit && !stop && !at_last |=> pc_ff == $past(pc_ff) + 6'h01)
    else $error("mid block jump");
  jump_target_a: assert property (jump && !stop |=> pc_ff == $past(br_tgt) && bst_ff == $past(br_nxt))
    else $error("jump target wrong");
  eq_branch_a: assert property (run && block_end_bit && br_en[2] && eq_a && !stop |=> pc_ff == $past(br_tgt))
    else $error("equal flag did not branch");
  start_zero_a: assert property (start && seq_ff != SEQ_RUN |=> run && pc_ff == 6'h00)
    else $error("start not at zero");
  last_done_a: assert property (run && at_last && !jump && !stop |=> done_ff && !run)
    else $error("no stop at last");
  cond_eval_a: assert property (run && block_end_bit && !cond && !at_last && !stop |=> $past(pc_ff) + 6'h01 == pc_ff)
    else $error("jump without condition");
  store_sel_a: assert property (run |-> cw == (sel_ff ? store1[pc_ff] : store0[pc_ff]))
    else $error("wrong control store");
  apb_wait_a: assert property (access && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb answer timing");
  cov_jump_c: cover property (jump);
  cov_done_c: cover property (run ##1 done_ff);
  cov_eq_c: cover property (run && eq_a && block_end_bit);

  // An error answer only ever travels with ready
  slverr_ready_a: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");

  // Ready is a single-cycle pulse, never held
  ready_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");

  // Read data is zero outside the answering cycle
  rdata_quiet_a: assert property (!pready_ff |-> prdata_ff == 32'h0000_0000)
    else $error("stray read data");

  // The control word output is cleared once the engine stops running
  idle_word_a: assert property (!run |=> ctrl_word_ff == 32'h0000_0000)
    else $error("word shown while idle");

  // A stop request while running always returns the sequencer to idle
  stop_idle_a: assert property (run && stop |=> seq_ff == SEQ_IDLE)
    else $error("stop ignored");

  // While idle the program counter only moves on a start request
  idle_hold_a: assert property (!run && !start |=> $stable(pc_ff))
    else $error("counter moved while idle");

  // Pin globals reach the condition logic only through the second flop
  glob_sync_a: assert property (glob_s_ff == $past(glob_m_ff))
    else $error("global sync skipped");

  // Extra coverage: a stop while running and a global-driven jump
  cov_stop_c: cover property (run && stop);
  cov_glob_c: cover property (jump && |(glob_s_ff & br_en[5:4]));
endmodule

// ### verilog/fab_pkg.sv
/*
  Shared constants for the filter address and branch controller: APB map,
  control word fields, branch table fields and address unit function codes.
  Assumes a 32-bit APB bus and a single 50 MHz system clock.
*/
package fab_pkg;
  // APB register map (byte addresses)
  localparam logic [11:0] CTRL_OFS      = 12'h0000;
  localparam logic [11:0] STATUS_OFS    = 12'h0004;
  localparam logic [11:0] LAST_OFS      = 12'h0008;
  localparam logic [11:0] ADDR_OFS      = 12'h000C;
  localparam logic [11:0] STORE0_BASE   = 12'h0100;
  localparam logic [11:0] STORE1_BASE   = 12'h0200;
  localparam logic [11:0] BRANCH_BASE   = 12'h0300;
  localparam logic [11:0] ACU_A_BASE    = 12'h0400;
  localparam logic [11:0] ACU_B_BASE    = 12'h0440;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SEL_BIT   = 1;
  localparam int CTRL_STOP_BIT  = 2;
  // Sizes
  localparam int PC_W    = 6;
  localparam int CS_DEPTH = 64;
  localparam int ST_W    = 3;
  localparam int BR_DEPTH = 8;
  localparam int AW      = 7;
  localparam int ACU_RAM_DEPTH = 16;
  localparam int COND_W  = 6;
  // Control word fields
  localparam int CW_EOB_BIT  = 31;
  localparam int CW_ARAM_LSB = 27;
  localparam int CW_ACUA_LSB = 23;
  localparam int CW_ACUB_LSB = 19;
  // Branch table entry fields
  localparam int BR_TGT_LSB  = 0;
  localparam int BR_NXT_LSB  = 6;
  localparam int BR_EN_LSB   = 9;
  // Address limits
  localparam logic [AW-1:0] ADDR_TOP = 7'h7F;
  // Address unit function codes
  localparam logic [3:0] HOLD_OP        = 4'h0;
  localparam logic [3:0] INC_OP         = 4'h1;
  localparam logic [3:0] DEC_OP         = 4'h2;
  localparam logic [3:0] READ_OP        = 4'h3;
  localparam logic [3:0] WRITE_OP       = 4'h4;
  localparam logic [3:0] LOAD_STEP_OP   = 4'h5;
  localparam logic [3:0] LOAD_LOW_OP    = 4'h6;
  localparam logic [3:0] LOAD_UP_OP     = 4'h7;
  localparam logic [3:0] STORE_LOW_OP   = 4'h8;
  localparam logic [3:0] WRAP_ON_OP     = 4'h9;
  localparam logic [3:0] WRAP_OFF_OP    = 4'hA;
  localparam logic [3:0] CLEAR_OP       = 4'hB;
  localparam logic [3:0] STEP_UP_OP     = 4'hC;
  localparam logic [3:0] STEP_DOWN_OP   = 4'hD;
  localparam logic [3:0] STORE_UPPER_OP = 4'hE;
  localparam logic [3:0] STORE_STEP_OP  = 4'hF;
  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN  = 3'b010,
    SEQ_DONE = 3'b100
  } fab_seq_t;
endpackage
